/* logic/config_load_pkg.sv */
// Shared constants and types of the configuration loader
package config_load_pkg;

    // Clock rate and generated configuration clock
    localparam int CLK_MHZ = 100;
    localparam int CFG_CLK_PERIOD_NS = 80;
    localparam int CFG_CLK_HALF = CFG_CLK_PERIOD_NS * CLK_MHZ / 2000;
    localparam logic [2:0] CFG_CLK_HALF_LAST = 3'(CFG_CLK_HALF - 1);

    // Memory clear and start-up durations
    localparam int CLEAR_TIME_NS = 1000;
    localparam int CLEAR_CYCLES = CLEAR_TIME_NS * CLK_MHZ / 1000;
    localparam logic [7:0] CLEAR_LAST = 8'(CLEAR_CYCLES - 1);
    localparam logic [7:0] STARTUP_LAST = 8'h07;

    // Mode-select pin codes
    localparam logic [2:0] MODE_MASTER_PAR = 3'h3;
    localparam logic [2:0] MODE_SCAN = 3'h5;

    // Test access port instruction register
    localparam int IR_LEN = 6;
    localparam logic [5:0] IR_CAPTURE = 6'h01;
    localparam logic [5:0] IR_CFG_IN = 6'h05;
    localparam logic [5:0] IR_RESTART = 6'h0B;
    localparam logic [5:0] IR_BYPASS = 6'h3F;

    // Synchroniser reset values: program request idles high
    localparam logic [7:0] PIN_IDLE = 8'h80;
    localparam logic [7:0] DATA_IDLE = 8'h00;

    typedef enum logic [2:0] {
        SEQ_CLEAR, SEQ_LOAD, SEQ_WAIT_DONE, SEQ_STARTUP, SEQ_USER
    } seqState_t;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR,
        TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
        TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } tapState_t;

    typedef struct packed {
        logic fromScan;
        logic [7:0] data;
    } loadWord_t;

endpackage

/* logic/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
module pin_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Pins and clean result
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinOut
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // First stage feeds only the second; change taken once s2 and s3 agree
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            pinOut <= INIT;
        end
        else
        begin
            s1 <= pinIn;
            s2 <= s1;
            s3 <= s2;
            pinOut <= (s2 & s3) | (pinOut & (s2 ^ s3));
        end
    end
endmodule // pin_sync

/* logic/load_buffer.sv */
// Two-entry buffer in the configuration data path
module load_buffer (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    input wire logic flush,
    // Filling side
    input wire config_load_pkg::loadWord_t inWord,
    input wire logic inValid,
    output logic inReady,
    // Draining side
    output config_load_pkg::loadWord_t outWord,
    output logic outValid,
    input wire logic outReady
);
    import config_load_pkg::*;

    loadWord_t ent1;
    logic [1:0] count;
    wire push = inValid & inReady;
    wire pop = outValid & outReady;

    assign inReady = (count != 2'h2);
    assign outValid = (count != 2'h0);

    // Head always sits in outWord so the data output comes from a flop
    always_ff @(posedge mclk)
    begin
        if (reset | flush)
        begin
            count <= 2'h0;
            outWord <= '0;
            ent1 <= '0;
        end
        else
        begin
            if (push & ~pop)
            begin
                if (count == 2'h0)
                    outWord <= inWord;
                else
                    ent1 <= inWord;
                count <= count + 2'h1;
            end
            else if (pop & ~push)
            begin
                outWord <= ent1;
                count <= count - 2'h1;
            end
            else if (push & pop)
            begin
                outWord <= (count == 2'h1) ? inWord : ent1;
                ent1 <= inWord;
            end
        end
    end
endmodule // load_buffer

/* logic/config_load_sequencer.sv */
// Configuration loader: clear, load, start-up, parallel and scan ports
// Notes on behaviour
// - Configuration starts after reset and again on each program request.
// - Sequence is memory clear, data load, then start-up of user logic.
// - Master parallel mode takes bytes and generates the clock itself.
// - In master mode the configuration clock pin is bidirectional; the code never reads configClockIn.
// - Master parallel timing matches slave parallel; device sources clock.
// - Scan configuration runs wholly over the test access port pins.
// - Scan port accepts configuration data whatever the mode pins say.
// - Scan mode on the mode pins disables every other configuration mode.
// - With active drive on, done pin is driven high when finished.
// - With active drive off, done pin is open-drain with pull-up.
module config_load_sequencer (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Program request and mode pins
    input wire logic programRequestN,
    input wire logic [2:0] modeSelect,
    // Configuration clock pin and parallel data
    input wire logic configClockIn,
    output logic configClockOut,
    output logic configClockOe,
    input wire logic [7:0] parallelData,
    // Test access port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoOe,
    // Done pin
    input wire logic doneIn,
    output logic doneOut,
    output logic doneOe,
    // Options
    input wire logic doneActiveDrive,
    input wire logic [15:0] imageLength,
    // Configuration memory write side
    output logic memClear,
    output config_load_pkg::loadWord_t memWord,
    output logic memValid,
    input wire logic memReady,
    // Status
    output config_load_pkg::seqState_t phase,
    output logic configDone,
    output logic userActive,
    output logic scanOverrun
);
    import config_load_pkg::*;

    logic [7:0] pinSync;
    logic [7:0] dataSync;
    logic tckPrev;
    logic [7:0] phaseCnt;
    logic [15:0] srcCount;
    logic [15:0] memCount;
    logic [2:0] halfCnt;
    logic restartPulse;
    tapState_t tapState;
    tapState_t next_tapState;
    logic [5:0] ir;
    logic [5:0] irShift;
    logic [7:0] drShift;
    logic [2:0] bitCnt;
    logic bypassBit;
    logic bufInReady;
    loadWord_t bufIn;
    seqState_t next_phase;

    // Pins from outside the clock domain pass four flops
    pin_sync #(.W(8), .INIT(PIN_IDLE)) ctrlSync (
        .mclk(mclk),
        .reset(reset),
        .pinIn({programRequestN, doneIn, tdi, tms, tck, modeSelect}),
        .pinOut(pinSync)
    );

    pin_sync #(.W(8), .INIT(DATA_IDLE)) dataSyncU (
        .mclk(mclk),
        .reset(reset),
        .pinIn(parallelData),
        .pinOut(dataSync)
    );

    // Named views of the clean pins
    wire programActive = ~pinSync[7];
    wire doneHigh = pinSync[6];
    wire tdiS = pinSync[5];
    wire tmsS = pinSync[4];
    wire tckS = pinSync[3];
    wire [2:0] modeS = pinSync[2:0];
    wire tckRise = tckS & ~tckPrev;
    wire tckFall = ~tckS & tckPrev;

    // Mode decode; scan mode shuts the parallel port off entirely
    wire scanOnly = (modeS == MODE_SCAN);
    wire masterPar = (modeS == MODE_MASTER_PAR) & ~scanOnly;
    wire loading = (phase == SEQ_LOAD);
    wire roomLeft = (srcCount != imageLength);
    wire scanSelected = (ir == IR_CFG_IN);

    // Parallel byte taken on the rising edge the device itself drives;
    // the clock is held low while the buffer is full so no byte is lost
    wire halfDone = (halfCnt == CFG_CLK_HALF_LAST);
    wire parEnable = masterPar & loading & roomLeft & ~scanSelected;
    wire parPush = halfDone & ~configClockOut & parEnable & bufInReady;

    // Scan byte completes on the eighth shifted bit; accepted in any mode
    wire scanByte = tckRise & (tapState == TAP_SHIFT_DR) & scanSelected
        & (bitCnt == 3'h7);
    wire scanWant = scanByte & loading & roomLeft;
    wire scanPush = scanWant & bufInReady;
    wire pushAny = parPush | scanPush;

    // Buffer input word
    assign bufIn.fromScan = scanPush;
    assign bufIn.data = scanPush ? {tdiS, drShift[7:1]} : dataSync;

    load_buffer dataBuf (
        .mclk(mclk),
        .reset(reset),
        .flush(restartPulse),
        .inWord(bufIn),
        .inValid(pushAny),
        .inReady(bufInReady),
        .outWord(memWord),
        .outValid(memValid),
        .outReady(memReady)
    );

    // Restart on program request or the scan restart instruction
    wire irRestart = tckRise & (tapState == TAP_UPD_IR)
        & (irShift == IR_RESTART);
    wire restartNow = programActive | irRestart;
    wire memTake = memValid & memReady;
    wire loadFinished = (memCount == imageLength) & ~memValid;

    // Sequence of the five phases
    always_comb
    begin
        next_phase = phase;
        case (phase)
            SEQ_CLEAR:
                if (phaseCnt == CLEAR_LAST)
                    next_phase = SEQ_LOAD;
            SEQ_LOAD:
                if (loadFinished)
                    next_phase = SEQ_WAIT_DONE;
            SEQ_WAIT_DONE:
                if (doneHigh)
                    next_phase = SEQ_STARTUP;
            SEQ_STARTUP:
                if (phaseCnt == STARTUP_LAST)
                    next_phase = SEQ_USER;
            SEQ_USER:
                next_phase = SEQ_USER;
            default:
                next_phase = SEQ_CLEAR;
        endcase
        if (restartNow)
            next_phase = SEQ_CLEAR;
    end

    // Sequence state and counters
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            phase <= SEQ_CLEAR;
            phaseCnt <= 8'h00;
            restartPulse <= 1'b1;
        end
        else
        begin
            phase <= next_phase;
            restartPulse <= restartNow;
            if (restartNow | (next_phase != phase))
                phaseCnt <= 8'h00;
            else
                phaseCnt <= phaseCnt + 8'h01;
        end
    end

    // Byte counts on both sides of the buffer
    always_ff @(posedge mclk)
    begin
        if (reset | restartPulse)
        begin
            srcCount <= 16'h0000;
            memCount <= 16'h0000;
        end
        else
        begin
            if (pushAny)
                srcCount <= srcCount + 16'h0001;
            if (memTake)
                memCount <= memCount + 16'h0001;
        end
    end

    // Clock divider; the device sources the configuration clock
    always_ff @(posedge mclk)
    begin
        if (reset | ~masterPar)
        begin
            halfCnt <= 3'h0;
            configClockOut <= 1'b0;
        end
        else if (halfDone)
        begin
            if (configClockOut)
            begin
                configClockOut <= 1'b0;
                halfCnt <= 3'h0;
            end
            else if (parPush)
            begin
                configClockOut <= 1'b1;
                halfCnt <= 3'h0;
            end
        end
        else
            halfCnt <= halfCnt + 3'h1;
    end

    // Test access port state transitions, one per rising tck
    always_comb
    begin
        case (tapState)
            TAP_RESET: next_tapState = tmsS ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_tapState = tmsS ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_tapState = tmsS ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_tapState = tmsS ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_tapState = tmsS ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: next_tapState = tmsS ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_tapState = tmsS ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: next_tapState = tmsS ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: next_tapState = tmsS ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: next_tapState = tmsS ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: next_tapState = tmsS ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_tapState = tmsS ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: next_tapState = tmsS ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_tapState = tmsS ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: next_tapState = tmsS ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: next_tapState = tmsS ? TAP_SEL_DR : TAP_IDLE;
            default: next_tapState = TAP_RESET;
        endcase
    end

    // Port state, instruction and shift registers on rising tck
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            tckPrev <= 1'b0;
            tapState <= TAP_RESET;
            ir <= IR_BYPASS;
            irShift <= IR_CAPTURE;
            drShift <= 8'h00;
            bitCnt <= 3'h0;
            bypassBit <= 1'b0;
        end
        else
        begin
            tckPrev <= tckS;
            if (tckRise)
            begin
                tapState <= next_tapState;
                case (tapState)
                    TAP_RESET: ir <= IR_BYPASS;
                    TAP_CAP_IR: irShift <= IR_CAPTURE;
                    TAP_SHIFT_IR: irShift <= {tdiS, irShift[IR_LEN-1:1]};
                    TAP_UPD_IR: ir <= irShift;
                    TAP_CAP_DR: bitCnt <= 3'h0;
                    TAP_SHIFT_DR:
                    begin
                        drShift <= {tdiS, drShift[7:1]};
                        bitCnt <= bitCnt + 3'h1;
                        bypassBit <= tdiS;
                    end
                    default: bypassBit <= bypassBit;
                endcase
            end
        end
    end

    // Test data out changes on falling tck, enabled only while shifting
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            tdo <= 1'b0;
            tdoOe <= 1'b0;
        end
        else if (tckFall)
        begin
            tdoOe <= (tapState == TAP_SHIFT_IR) | (tapState == TAP_SHIFT_DR);
            if (tapState == TAP_SHIFT_IR)
                tdo <= irShift[0];
            else if (scanSelected)
                tdo <= drShift[0];
            else
                tdo <= bypassBit;
        end
    end

    // A scan byte that finds the buffer full is dropped and flagged;
    // the host owns tck and cannot be stalled
    always_ff @(posedge mclk)
    begin
        if (reset)
            scanOverrun <= 1'b0;
        else if (scanWant & ~bufInReady)
            scanOverrun <= 1'b1;
        else if (restartPulse)
            scanOverrun <= 1'b0;
    end

    // Pin drivers and status, all registered
    wire doneLevel = (phase == SEQ_WAIT_DONE) | (phase == SEQ_STARTUP)
        | (phase == SEQ_USER);
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            doneOut <= 1'b0;
            doneOe <= 1'b1;
            configClockOe <= 1'b0;
            memClear <= 1'b1; // Reset already sits in the clear phase
            configDone <= 1'b0;
            userActive <= 1'b0;
        end
        else
        begin
            // Active drive: high when done; otherwise pull low or release
            doneOut <= doneActiveDrive & doneLevel;
            doneOe <= doneActiveDrive | ~doneLevel;
            configClockOe <= masterPar & (phase != SEQ_USER);
            memClear <= (next_phase == SEQ_CLEAR);
            configDone <= doneLevel;
            userActive <= (next_phase == SEQ_USER);
        end
    end
endmodule // config_load_sequencer

/* tb/config_load_chk.sv */
// Port-level property checker for the configuration loader
module config_load_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Pins and options
    input wire logic programRequestN,
    input wire logic [2:0] modeSelect,
    input wire logic configClockOut,
    input wire logic configClockOe,
    input wire logic doneActiveDrive,
    input wire logic doneOut,
    input wire logic doneOe,
    // Memory side and status
    input wire logic memClear,
    input wire logic memValid,
    input wire config_load_pkg::seqState_t phase,
    input wire logic userActive
);
    import config_load_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic [7:0] clrCnt;

    // Clear length; the window allows for the request pin synchroniser
    always_ff @(posedge mclk)
    begin
        if (reset || !programRequestN || !memClear)
            clrCnt <= 8'h00;
        else
            clrCnt <= clrCnt + 8'h01;
    end

    // Sequence order and durations
    clear_length_a: assert property ($fell(memClear) |->
        clrCnt inside {[8'h64:8'h69]}) else $error("clear phase length off");
    load_follows_a: assert property ($fell(memClear) |->
        phase == SEQ_LOAD) else $error("load does not follow clear");
    startup_len_a: assert property ($rose(phase == SEQ_STARTUP) |->
        (phase == SEQ_STARTUP) [*8] ##1 phase == SEQ_USER)
        else $error("start-up length off");
    restart_a: assert property (!programRequestN [*6] |->
        phase == SEQ_CLEAR && memClear) else $error("request not honoured");
    // Generated clock: cause, shape and the byte it takes
    clk_cause_a: assert property ($rose(configClockOut) |->
        configClockOe && phase == SEQ_LOAD && modeSelect == MODE_MASTER_PAR)
        else $error("clock pulse outside master parallel load");
    clk_high_a: assert property ($rose(configClockOut) |->
        configClockOut [*4] ##1 !configClockOut) else $error("clock high time");
    byte_push_a: assert property ($rose(configClockOut) |->
        memValid) else $error("byte not pushed on clock rise");
    // Done pin drive options
    drive_done_a: assert property (userActive && doneActiveDrive |->
        doneOe && doneOut) else $error("done pin not driven high");
    open_drain_a: assert property (!doneActiveDrive |->
        !(doneOe && doneOut)) else $error("open-drain done driven high");
    // Main scenarios reached
    cover property ($rose(userActive));
    cover property ($rose(configClockOut));
    cover property ($fell(programRequestN));
endmodule // config_load_chk

bind config_load_sequencer config_load_chk i_config_load_chk (.mclk, .reset,
    .programRequestN, .modeSelect, .configClockOut, .configClockOe,
    .doneActiveDrive, .doneOut, .doneOe, .memClear, .memValid, .phase,
    .userActive);

/* tb/prom_model.sv */
// Byte-wide configuration memory answering the generated clock
module prom_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    input wire logic restartN,
    // Clock pin, image and data pins
    input wire logic clkPin,
    input wire logic clkOe,
    input wire logic [7:0] image [0:7],
    output logic [7:0] dataPin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic prevClk;
    logic [2:0] idx;

    // Step a cycle after each rise, so the byte stays steady a whole period
    always @(posedge mclk)
    begin
        prevClk <= clkPin;
        if (reset || !restartN)
            idx <= 3'h0;
        else if (clkPin && !prevClk)
            idx <= idx + 3'h1;
    end

    // Clock pin not driven: memory not addressed, so show junk
    assign dataPin = clkOe ? image[idx] : ~image[idx];
endmodule // prom_model

/* tb/tb_config_load_sequencer.sv */
// Self-checking bench for the configuration loader
module tb_config_load_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    import config_load_pkg::*;
    logic mclk, reset, programRequestN, doneActiveDrive, memReady;
    logic tck, tms, tdi, tdo, tdoOe, doneOut, doneOe, memClear, memValid;
    logic configClockOut, configClockOe, configDone, userActive, scanOverrun;
    logic [2:0] modeSelect;
    logic [7:0] parallelData;
    logic [7:0] image [0:7];
    logic [15:0] imageLength;
    loadWord_t memWord;
    seqState_t phase;
    loadWord_t expQ [$];
    int n_mismatch = 0;
    int n_compared = 0;
    int seed = 70;
    int cycles = 0;
    // Pulled-up pins: level seen by every party
    wire clkPin = configClockOe ? configClockOut : 1'b1;
    wire donePin = doneOe ? doneOut : 1'b1;

    config_load_sequencer i_config_load_sequencer (.mclk, .reset,
        .programRequestN, .modeSelect, .configClockIn(clkPin),
        .configClockOut, .configClockOe, .parallelData, .tck, .tms, .tdi,
        .tdo, .tdoOe, .doneIn(donePin), .doneOut, .doneOe,
        .doneActiveDrive, .imageLength, .memClear, .memWord, .memValid,
        .memReady, .phase, .configDone, .userActive, .scanOverrun);
    prom_model i_prom_model (.mclk, .reset, .restartN(programRequestN),
        .clkPin, .clkOe(configClockOe), .image, .dataPin(parallelData));

    // Clock generator
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One test-port clock of 80 ns
    task automatic tapBit(input logic m, input logic d);
        tms = m;
        tdi = d;
        #40 tck = 1'b1;
        #40 tck = 1'b0;
    endtask

    task automatic tmsWalk(input logic [7:0] t, input int n);
        for (int i = 0; i < n; i++)
            tapBit(t[i], 1'b0);
    endtask

    // Load an instruction, then shift n random bytes LSB first
    task automatic scanLoad(input logic [5:0] code, input int n);
        logic [7:0] b;
        tmsWalk(8'h1F, 5);
        tmsWalk(8'h06, 5);
        // In Shift-IR now; tdo lags the falling tck by the pin synchroniser
        #60;
        check({7'h00, tdoOe, tdo}, {7'h00, 1'b1, IR_CAPTURE[0]});
        for (int i = 0; i < IR_LEN; i++)
            tapBit(i == IR_LEN - 1, code[i]);
        tmsWalk(8'h05, 5);
        for (int k = 0; k < n; k++)
        begin
            b = 8'($random(seed));
            expQ.push_back({1'b1, b});
            for (int i = 0; i < 8; i++)
                tapBit(k == n - 1 && i == 7, b[i]);
        end
        tmsWalk(8'h01, 2);
    endtask

    // Program request pulse with new mode and done option
    task automatic restart(input logic [2:0] mode, input logic drive);
        programRequestN = 1'b0;
        #80;
        modeSelect = mode;
        doneActiveDrive = drive;
        imageLength = 16'h0004;
        #20;
        programRequestN = 1'b1;
        for (int i = 0; i < 300 && phase !== SEQ_LOAD; i++)
            #10;
        check({6'h00, phase}, {6'h00, SEQ_LOAD});
    endtask

    task automatic awaitUser(input logic drive);
        for (int i = 0; i < 3000 && userActive !== 1'b1; i++)
            #10;
        check({8'h00, userActive}, 9'h001);
        check({7'h00, doneOe, doneOut}, drive ? 9'h003 : 9'h000);
        check({8'h00, scanOverrun}, 9'h000);
        check({8'h00, configDone}, 9'h001);
        check({8'h00, tdoOe}, 9'h000);
        check(9'(expQ.size()), 9'h000);
    endtask

    // Main sequence
    initial
    begin
        reset = 1'b1;
        programRequestN = 1'b1;
        modeSelect = MODE_MASTER_PAR;
        doneActiveDrive = 1'b0;
        imageLength = 16'h0006;
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        memReady = 1'b0;
        for (int i = 0; i < 8; i++)
            image[i] = 8'($random(seed));
        repeat (6) @(posedge mclk);
        #1 reset = 1'b0;
        for (int i = 0; i < 6; i++)
            expQ.push_back({1'b0, image[i]});
        awaitUser(1'b0);
        $display("Test parallel load finished");
        restart(MODE_SCAN, 1'b0);
        scanLoad(IR_CFG_IN, 4);
        awaitUser(1'b0);
        $display("Test scan-only load finished");
        restart(3'h0, 1'b1);
        scanLoad(IR_CFG_IN, 4);
        awaitUser(1'b1);
        $display("Test scan in other mode finished");
        // Restart instruction sends the device back into the clear phase
        scanLoad(IR_RESTART, 0);
        check({7'h00, userActive, memClear}, 9'h001);
        $display("Test scan restart finished");
        results();
    end

    // Watcher: looks half a cycle early, so no race with the launching edge
    always @(negedge mclk)
    begin
        if (memValid === 1'b1 && memReady === 1'b1)
        begin
            if (expQ.size() == 0)
            begin
                n_mismatch++;
                $display("mismatch at %0t: unexpected word", $time);
            end
            else
                check(memWord, expQ.pop_front());
        end
    end

    // Hang guard
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            results();
        end
    end

    // Sparse acceptance fills the buffer
    always @(posedge mclk)
        #1 memReady = ($random(seed) & 15) == 0;
endmodule // tb_config_load_sequencer
